// ---- hdl/group4_regs.v ----
// Local design decision: register access over APB.
`timescale 1ns/1ps
`include "group4_regs_defs.vh"

module group4_regs (
  // APB clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Test pattern controls to the serializer
  output reg  [3:0]  prbs_enable,
  output reg  [2:0]  pattern_code_line13,
  output reg  [2:0]  pattern_code_line14,
  output reg  [2:0]  pattern_code_line15,
  output reg  [2:0]  pattern_code_line16,
  output reg         per_output_pattern_select,
  // High-pass filter controls
  output reg         highpass_enable_group4,
  output reg  [3:0]  highpass_corner_k_group4,
  // Input pair selection, index into pairs 25..32
  output reg  [3:0]  input_pair_select,
  output reg         sixteen_input_mode
);

  // ****************************************
  // Register storage
  // ****************************************
  reg [15:0] pattern_hpf_q;
  reg [15:0] input_sel_q;
  reg [15:0] mode_ctrl_q;
  reg [15:0] conv_ctrl_q;

  // Merge a write into a 16-bit register honouring byte strobes and mask
  function [15:0] merge;
    input [15:0] old;
    input [31:0] wdata;
    input [3:0]  strb;
    input [15:0] mask;
    reg   [15:0] bytes;
    begin
      bytes = {strb[1] ? wdata[15:8] : old[15:8], strb[0] ? wdata[7:0] : old[7:0]};
      merge = bytes & mask;
    end
  endfunction

  // Reverse a 4-bit field; the register packs line 13 at the top, the ports at bit 0
  function [3:0] rev4;
    input [3:0] v;
    begin
      rev4 = {v[0], v[1], v[2], v[3]};
    end
  endfunction

  // Full 12-bit compare, so aliases of a register cannot take a write
  function addr_is;
    input [11:0] a;
    input [11:0] ref_addr;
    begin
      addr_is = (a == ref_addr);
    end
  endfunction

  // Force a 3-bit field to zero while its enable is off
  function [2:0] gate3;
    input       en;
    input [2:0] v;
    begin
      gate3 = en ? v : 3'h0;
    end
  endfunction

  // Force a 4-bit field to zero while its enable is off
  function [3:0] gate4;
    input       en;
    input [3:0] v;
    begin
      gate4 = en ? v : 4'h0;
    end
  endfunction

  // ****************************************
  // APB decode
  // ****************************************
  wire setup_phase = psel & ~penable;
  wire access_done = psel & penable & pready;
  wire hit_pat     = addr_is(paddr, `ADDR_PATTERN_HPF);
  wire hit_in      = addr_is(paddr, `ADDR_INPUT_SEL);
  wire hit_mode    = addr_is(paddr, `ADDR_MODE_CTRL);
  wire hit_conv    = addr_is(paddr, `ADDR_CONV_CTRL);
  wire hit_any     = hit_pat | hit_in | hit_mode | hit_conv;
  wire wr_take     = access_done & pwrite & hit_any;

  // Read mux; reserved bits are held at zero in storage so they read zero
  reg [15:0] rd_mux;
  always @* begin
    case (1'b1)
      hit_pat:  rd_mux = pattern_hpf_q;
      hit_in:   rd_mux = input_sel_q;
      hit_mode: rd_mux = mode_ctrl_q;
      hit_conv: rd_mux = conv_ctrl_q;
      default:  rd_mux = 16'h0000;
    endcase
  end

  // ****************************************
  // APB answer
  // ****************************************
  // Answer the cycle after setup; a registered pready keeps decode off the bus path
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_phase;
    end
  end

  // Unmapped offsets answer with an error and leave every register alone
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup_phase & ~hit_any;
    end
  end

  // Read data stands only in the answer cycle of a read, zero otherwise
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_phase & ~pwrite) begin
      prdata <= {16'h0000, rd_mux};
    end else begin
      prdata <= 32'h00000000;
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  // One strobe per register; each commits only in the completing access phase
  wire wr_pat  = wr_take & hit_pat;
  wire wr_in   = wr_take & hit_in;
  wire wr_mode = wr_take & hit_mode;
  wire wr_conv = wr_take & hit_conv;

  // Pattern and filter register; bit 5 is masked so a careless write cannot
  // leave it set, and a byte strobe keeps the other half untouched
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pattern_hpf_q <= `RST_PATTERN_HPF;
    end else if (wr_pat) begin
      pattern_hpf_q <= merge(pattern_hpf_q, pwdata, pstrb, `MASK_PATTERN_HPF);
    end
  end

  // Input select and pattern register; bits 15..12 and 1..0 are masked and
  // therefore always read back as zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_sel_q <= `RST_INPUT_SEL;
    end else if (wr_in) begin
      input_sel_q <= merge(input_sel_q, pwdata, pstrb, `MASK_INPUT_SEL);
    end
  end

  // Mode register; only the per-output pattern select bit is stored, the rest
  // of that register belongs to other blocks
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ctrl_q <= `RST_MODE_CTRL;
    end else if (wr_mode) begin
      mode_ctrl_q <= merge(mode_ctrl_q, pwdata, pstrb, `MASK_MODE_CTRL);
    end
  end

  // Converter control; only the sixteen-input mode bit is stored, so other
  // converter settings cannot alias into this block
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_ctrl_q <= `RST_CONV_CTRL;
    end else if (wr_conv) begin
      conv_ctrl_q <= merge(conv_ctrl_q, pwdata, pstrb, `MASK_CONV_CTRL);
    end
  end

  // ****************************************
  // Field extraction
  // ****************************************
  // Raw fields, named once so the output logic reads like the register map
  wire       ind_sel  = mode_ctrl_q[`POS_PAT_SEL_IND];
  wire       mode16   = conv_ctrl_q[`POS_MODE16];
  wire       hpf_on   = pattern_hpf_q[`POS_HPF_EN];
  wire [3:0] k_field  = pattern_hpf_q[`POS_CORNER_HI:`POS_CORNER_LO];
  wire [3:0] prbs_raw = pattern_hpf_q[`POS_PRBS_LINE13:`POS_PRBS_LINE16];
  wire [2:0] code13   = pattern_hpf_q[`POS_CODE13_HI:`POS_CODE13_LO];
  wire [2:0] code14   = pattern_hpf_q[`POS_CODE14_HI:`POS_CODE14_LO];
  wire [2:0] code15   = input_sel_q[`POS_CODE15_HI:`POS_CODE15_LO];
  wire [2:0] code16   = input_sel_q[`POS_CODE16_HI:`POS_CODE16_LO];
  wire [3:0] pair_raw = input_sel_q[`POS_INSEL13:`POS_INSEL16];

  // ****************************************
  // Next values of the outputs
  // ****************************************
  // Gating sits here so every output flop below is a plain copy
  wire       per_output_pattern_select_d = ind_sel;
  wire [3:0] prbs_enable_d               = gate4(ind_sel, rev4(prbs_raw));
  wire [2:0] pattern_code_line13_d       = gate3(ind_sel, code13);
  wire [2:0] pattern_code_line14_d       = gate3(ind_sel, code14);
  wire [2:0] pattern_code_line15_d       = gate3(ind_sel, code15);
  wire [2:0] pattern_code_line16_d       = gate3(ind_sel, code16);
  wire       highpass_enable_group4_d    = hpf_on;
  // Corner k passes only while the filter runs; its legal range is software's duty
  wire [3:0] highpass_corner_k_group4_d  = gate4(hpf_on, k_field);
  // Bit 0 is converter 13; zero picks the lower pair of each couple
  wire [3:0] input_pair_select_d         = gate4(mode16, rev4(pair_raw));
  wire       sixteen_input_mode_d        = mode16;

  // ****************************************
  // Output flops
  // ****************************************
  // Outputs registered once more so they come straight from flip-flops.
  // Gated copies cost one cycle of latency after a write; the datapath tolerates it.

  // Copy of the per-output select; the serializer uses it to pick its source
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_output_pattern_select <= 1'b0;
    end else begin
      per_output_pattern_select <= per_output_pattern_select_d;
    end
  end

  // PRBS enables, bit 0 for line 13
  // Held at zero in common mode, so stale enables cannot leak out
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prbs_enable <= 4'h0;
    end else begin
      prbs_enable <= prbs_enable_d;
    end
  end

  // Pattern code of line 13
  // Zero while per-output mode is off, matching the common pattern path
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pattern_code_line13 <= 3'h0;
    end else begin
      pattern_code_line13 <= pattern_code_line13_d;
    end
  end

  // Pattern code of line 14
  // Zero while per-output mode is off, matching the common pattern path
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pattern_code_line14 <= 3'h0;
    end else begin
      pattern_code_line14 <= pattern_code_line14_d;
    end
  end

  // Pattern code of line 15
  // Zero while per-output mode is off, matching the common pattern path
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pattern_code_line15 <= 3'h0;
    end else begin
      pattern_code_line15 <= pattern_code_line15_d;
    end
  end

  // Pattern code of line 16
  // Zero while per-output mode is off, matching the common pattern path
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pattern_code_line16 <= 3'h0;
    end else begin
      pattern_code_line16 <= pattern_code_line16_d;
    end
  end

  // Filter enable for converters 13 to 16
  // A plain copy; the filter itself lives in the datapath
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      highpass_enable_group4 <= 1'b0;
    end else begin
      highpass_enable_group4 <= highpass_enable_group4_d;
    end
  end

  // Corner k, zero while the filter is off
  // Out-of-range k is passed through unchanged; software keeps it in range
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      highpass_corner_k_group4 <= 4'h0;
    end else begin
      highpass_corner_k_group4 <= highpass_corner_k_group4_d;
    end
  end

  // Input pair selects, bit 0 for converter 13
  // Zero outside sixteen-input mode, so other modes see a clean default
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_pair_select <= 4'h0;
    end else begin
      input_pair_select <= input_pair_select_d;
    end
  end

  // Sixteen-input mode flag for the input multiplexer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sixteen_input_mode <= 1'b0;
    end else begin
      sixteen_input_mode <= sixteen_input_mode_d;
    end
  end

endmodule

// ---- include/group4_regs_defs.vh ----
`ifndef GROUP4_REGS_DEFS_VH
`define GROUP4_REGS_DEFS_VH

// ****************************************
// Register indices and byte addresses
// ****************************************
`define IDX_PATTERN_HPF      8'h39
`define IDX_INPUT_SEL        8'h3b
`define IDX_MODE_CTRL        8'h04
`define IDX_CONV_CTRL        8'h3d
`define ADDR_PATTERN_HPF     12'h0e4
`define ADDR_INPUT_SEL       12'h0ec
`define ADDR_MODE_CTRL       12'h010
`define ADDR_CONV_CTRL       12'h0f4

// ****************************************
// Reset values
// ****************************************
`define RST_PATTERN_HPF      16'h0000
`define RST_INPUT_SEL        16'h0000
`define RST_MODE_CTRL        16'h0000
`define RST_CONV_CTRL        16'h0000

// ****************************************
// Field positions, first register
// ****************************************
`define POS_PRBS_LINE13      15
`define POS_PRBS_LINE16      12
`define POS_CODE13_HI        11
`define POS_CODE13_LO        9
`define POS_CODE14_HI        8
`define POS_CODE14_LO        6
`define POS_RSVD_A           5
`define POS_CORNER_HI        4
`define POS_CORNER_LO        1
`define POS_HPF_EN           0

// ****************************************
// Field positions, second register
// ****************************************
`define POS_INSEL13          11
`define POS_INSEL16          8
`define POS_CODE15_HI        7
`define POS_CODE15_LO        5
`define POS_CODE16_HI        4
`define POS_CODE16_LO        2

// ****************************************
// Field positions, own control registers
// ****************************************
`define POS_PAT_SEL_IND      8
`define POS_MODE16           0

// ****************************************
// Writable masks; reserved bits read zero
// ****************************************
`define MASK_PATTERN_HPF     16'hffdf
`define MASK_INPUT_SEL       16'h0ffc
`define MASK_MODE_CTRL       16'h0100
`define MASK_CONV_CTRL       16'h0001

`endif

// ---- verif/group4_regs_properties.sv ----
`timescale 1ns/1ps
`include "group4_regs_defs.vh"
// ****************************************
// Port checker
// ****************************************
module group4_regs_properties (
  // Clock and reset
  input wire        pclk,
  input wire        presetn,
  // APB slave side
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0]  pstrb,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Derived controls
  input wire [3:0]  prbs_enable,
  input wire [2:0]  pattern_code_line13,
  input wire [2:0]  pattern_code_line14,
  input wire [2:0]  pattern_code_line15,
  input wire [2:0]  pattern_code_line16,
  input wire        per_output_pattern_select,
  input wire        highpass_enable_group4,
  input wire [3:0]  highpass_corner_k_group4,
  input wire [3:0]  input_pair_select,
  input wire        sixteen_input_mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Write data fields, flipped where the output order runs opposite
  wire [3:0] prbs_w = {pwdata[12], pwdata[13], pwdata[14], pwdata[15]};
  wire [3:0] pair_w = {pwdata[8], pwdata[9], pwdata[10], pwdata[11]};
  wire [5:0] code_a = pwdata[11:6];
  wire [5:0] code_b = pwdata[7:2];
  wire [3:0] k_w    = pwdata[4:1];
  wire       en_w   = pwdata[0];
  // Write with both low byte strobes set that commits at this edge
  sequence commit_at(a);
    psel && penable && pready && pwrite && paddr == a && pstrb[1:0] == 2'h3;
  endsequence
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no answer in access phase");
  a_read_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_reserved_read: assert property (pready && !pwrite && paddr == `ADDR_PATTERN_HPF |->
    prdata[31:16] == 16'h0 && !prdata[5]) else $error("reserved bit read one");
  a_prbs_gated: assert property (!per_output_pattern_select |->
    prbs_enable == 4'h0 && pattern_code_line13 == 3'h0) else $error("pattern not gated");
  a_corner_gated: assert property (!highpass_enable_group4 |-> highpass_corner_k_group4 == 4'h0)
    else $error("corner not gated");
  a_pair_gated: assert property (!sixteen_input_mode |-> input_pair_select == 4'h0)
    else $error("pair select not gated");
  a_hpf_write: assert property (commit_at(`ADDR_PATTERN_HPF) |-> ##2
    highpass_enable_group4 == $past(en_w, 2)) else $error("filter enable wrong");
  a_corner_write: assert property (commit_at(`ADDR_PATTERN_HPF) ##0 en_w |-> ##2
    highpass_corner_k_group4 == $past(k_w, 2)) else $error("corner wrong");
  a_code_write: assert property (commit_at(`ADDR_PATTERN_HPF) ##0 per_output_pattern_select
    |-> ##2 {pattern_code_line13, pattern_code_line14} == $past(code_a, 2) &&
    prbs_enable == $past(prbs_w, 2)) else $error("line 13 14 pattern wrong");
  a_code_b_write: assert property (commit_at(`ADDR_INPUT_SEL) ##0 per_output_pattern_select
    |-> ##2 {pattern_code_line15, pattern_code_line16} == $past(code_b, 2))
    else $error("line 15 16 pattern wrong");
  a_pair_write: assert property (commit_at(`ADDR_INPUT_SEL) ##0 sixteen_input_mode |-> ##2
    input_pair_select == $past(pair_w, 2)) else $error("pair select wrong");
endmodule
bind group4_regs group4_regs_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .prbs_enable, .pattern_code_line13,
  .pattern_code_line14, .pattern_code_line15, .pattern_code_line16, .per_output_pattern_select,
  .highpass_enable_group4, .highpass_corner_k_group4, .input_pair_select, .sixteen_input_mode);

// ---- verif/group4_regs_tb.sv ----
`timescale 1ns/1ps
`include "group4_regs_defs.vh"
module group4_regs_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic [3:0] pstrb = 4'hf, prbs_enable, corner, pairs;
  logic [2:0] c13, c14, c15, c16;
  logic pready, pslverr, rerr, psel_out, hpf_en, mode16;
  int fail_count = 0, comparisons = 0;
  group4_regs uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .prbs_enable, .pattern_code_line13(c13),
    .pattern_code_line14(c14), .pattern_code_line15(c15), .pattern_code_line16(c16),
    .per_output_pattern_select(psel_out), .highpass_enable_group4(hpf_en),
    .highpass_corner_k_group4(corner), .input_pair_select(pairs), .sixteen_input_mode(mode16));
  // Clock, 5 ns period
  initial forever #2.5 pclk = ~pclk;
  task chk(input [31:0] s, input [31:0] x);
    comparisons++;
    if (s !== x) begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task end_sim;
    if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // One APB transfer; request held until pready is seen high
  task xfer(input w, input [11:0] a, input [31:0] d);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task rd(input [11:0] a, input [31:0] x, input e);
    xfer(0, a, 32'h0);
    chk(rdat, x);
    chk(rerr, e);
  endtask
  // Derived outputs follow the register one cycle later
  task settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask
  // Watchdog; the whole run needs well under a thousand cycles
  initial begin
    #20000;
    fail_count++;
    end_sim;
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    rd(`ADDR_PATTERN_HPF, 32'h0, 0);
    rd(`ADDR_INPUT_SEL, 32'h0, 0);
    rd(12'h100, 32'h0, 1);
    // Reserved bits set on purpose; they must not stick
    xfer(1, `ADDR_PATTERN_HPF, 32'h0000aaf5);
    xfer(1, `ADDR_INPUT_SEL, 32'h0000faa8);
    settle;
    chk(prbs_enable, 0);
    chk(c13, 0);
    chk(pairs, 0);
    chk(hpf_en, 1);
    chk(corner, 10);
    rd(`ADDR_PATTERN_HPF, 32'h0000aad5, 0);
    rd(`ADDR_INPUT_SEL, 32'h00000aa8, 0);
    xfer(1, `ADDR_MODE_CTRL, 32'h100);
    xfer(1, `ADDR_CONV_CTRL, 32'h1);
    settle;
    chk({prbs_enable, c13, c14}, {4'h5, 3'h5, 3'h3});
    chk({c15, c16, pairs}, {3'h5, 3'h2, 4'h5});
    chk({psel_out, mode16}, 2'h3);
    rd(`ADDR_MODE_CTRL, 32'h00000100, 0);
    rd(`ADDR_CONV_CTRL, 32'h00000001, 0);
    xfer(1, `ADDR_INPUT_SEL, 32'h00000554);
    settle;
    chk({c15, c16, pairs}, {3'h2, 3'h5, 4'ha});
    // Low byte only; the high byte keeps its pair selects
    @(posedge pclk);
    pstrb <= 4'h1;
    xfer(1, `ADDR_INPUT_SEL, 32'h0000ffff);
    pstrb <= 4'hf;
    settle;
    chk({c15, c16, pairs}, {3'h7, 3'h7, 4'ha});
    rd(`ADDR_INPUT_SEL, 32'h000005fc, 0);
    // Unmapped write is refused and changes nothing
    xfer(1, 12'h100, 32'h0000ffff);
    chk(rerr, 1'b1);
    rd(`ADDR_PATTERN_HPF, 32'h0000aad5, 0);
    xfer(1, `ADDR_PATTERN_HPF, 32'h00000004);
    settle;
    chk({prbs_enable, hpf_en, corner}, 9'h0);
    xfer(1, `ADDR_PATTERN_HPF, 32'h00000005);
    settle;
    chk({hpf_en, corner}, {1'b1, 4'h2});
    // Reset in mid-run clears every field and every output
    @(posedge pclk);
    presetn <= 0;
    settle;
    chk({prbs_enable, c13, c14, c15, c16, psel_out, hpf_en, corner, pairs, mode16}, 0);
    @(posedge pclk);
    presetn <= 1;
    rd(`ADDR_PATTERN_HPF, 32'h0, 0);
    rd(`ADDR_INPUT_SEL, 32'h0, 0);
    rd(`ADDR_MODE_CTRL, 32'h0, 0);
    end_sim;
  end
endmodule
